// *** rtl/spacing_pkg.sv ***
// Constants, types and timing limits for the DDR4 command spacing controller
package spacing_pkg;

    // ----------------------------------------
    // Clock and limit conversion
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 40000;

    function automatic int cyc(input int nck, input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) c = 1;
        return (nck > c) ? nck : c;
    endfunction

    // ----------------------------------------
    // Timing limits, cycles and picoseconds
    // ----------------------------------------
    localparam int COL_SAME_NCK = 5;
    localparam int COL_SAME_PS = 5000;
    localparam int COL_OTHER_NCK = 4;
    localparam int ACT_NCK = 4;
    localparam int ACT_OTHER_2K_PS = 5300;
    localparam int ACT_OTHER_SMALL_2400_PS = 3300;
    localparam int ACT_OTHER_SMALL_2666_PS = 3000;
    localparam int ACT_SAME_2K_PS = 6400;
    localparam int ACT_SAME_SMALL_PS = 4900;
    localparam int FAW_2K_NCK = 28;
    localparam int FAW_2K_PS = 30000;
    localparam int FAW_1K_NCK = 20;
    localparam int FAW_1K_PS = 21000;
    localparam int FAW_HALF_NCK = 16;
    localparam int FAW_HALF_2400_PS = 13000;
    localparam int FAW_HALF_2666_PS = 12000;
    localparam int WTR_OTHER_NCK = 2;
    localparam int WTR_OTHER_PS = 2500;
    localparam int WTR_SAME_NCK = 4;
    localparam int WTR_SAME_PS = 7500;
    localparam int RTP_NCK = 4;
    localparam int RTP_PS = 7500;
    localparam int WR_PS = 15000;
    localparam int CRC_DM_NCK = 5;
    localparam int CRC_DM_PS = 3750;
    localparam int MRD_NCK = 8;
    localparam int BURST_HALF_NCK = 4;

    localparam logic [7:0] COL_SAME_CYC = 8'(cyc(COL_SAME_NCK, COL_SAME_PS));
    localparam logic [7:0] COL_OTHER_CYC = 8'(COL_OTHER_NCK);
    localparam logic [7:0] ACT_OTHER_2K_CYC = 8'(cyc(ACT_NCK, ACT_OTHER_2K_PS));
    localparam logic [7:0] ACT_OTHER_2400_CYC = 8'(cyc(ACT_NCK, ACT_OTHER_SMALL_2400_PS));
    localparam logic [7:0] ACT_OTHER_2666_CYC = 8'(cyc(ACT_NCK, ACT_OTHER_SMALL_2666_PS));
    localparam logic [7:0] ACT_SAME_2K_CYC = 8'(cyc(ACT_NCK, ACT_SAME_2K_PS));
    localparam logic [7:0] ACT_SAME_SMALL_CYC = 8'(cyc(ACT_NCK, ACT_SAME_SMALL_PS));
    localparam logic [7:0] FAW_2K_CYC = 8'(cyc(FAW_2K_NCK, FAW_2K_PS));
    localparam logic [7:0] FAW_1K_CYC = 8'(cyc(FAW_1K_NCK, FAW_1K_PS));
    localparam logic [7:0] FAW_HALF_2400_CYC = 8'(cyc(FAW_HALF_NCK, FAW_HALF_2400_PS));
    localparam logic [7:0] FAW_HALF_2666_CYC = 8'(cyc(FAW_HALF_NCK, FAW_HALF_2666_PS));
    localparam logic [7:0] WTR_OTHER_CYC = 8'(cyc(WTR_OTHER_NCK, WTR_OTHER_PS));
    localparam logic [7:0] WTR_SAME_CYC = 8'(cyc(WTR_SAME_NCK, WTR_SAME_PS));
    localparam logic [7:0] RTP_CYC = 8'(cyc(RTP_NCK, RTP_PS));
    localparam logic [7:0] WR_CYC = 8'(cyc(1, WR_PS));
    localparam logic [7:0] CRC_DM_CYC = 8'(cyc(CRC_DM_NCK, CRC_DM_PS));
    localparam logic [7:0] MRD_CYC = 8'(MRD_NCK);
    localparam logic [7:0] BURST_HALF_CYC = 8'(BURST_HALF_NCK);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_ISSUED = 4'h8;
    localparam int CFG_PAGE_LSB = 0;
    localparam int CFG_GRADE_BIT = 2;
    localparam int CFG_CRC_DM_BIT = 3;
    localparam int CFG_CWL_LSB = 4;
    localparam int CFG_WIDTH = 9;
    localparam int STAT_HOLD_BIT = 0;
    localparam int STAT_STALL_LSB = 1;
    localparam int STAT_KIND_LSB = 8;
    localparam logic [8:0] CFG_RESET = 9'h092;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_RD = 3'h2,
        CMD_WR = 3'h3,
        CMD_PRE = 3'h4,
        CMD_MRS = 3'h5
    } cmd_kind_t;

    typedef enum logic [1:0] {
        PAGE_HALF = 2'h0,
        PAGE_1K = 2'h1,
        PAGE_2K = 2'h2
    } page_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } state_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [16:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [4:0] cwl;
        logic crc_dm;
        logic grade_2666;
        page_t page;
    } cfg_t;

endpackage

// *** rtl/elapsed_counter.sv ***
// Saturating count of cycles since the last restart
`timescale 1ns/100ps
`default_nettype none
module elapsed_counter #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic restart,
    output logic [W-1:0] count
);
    // Reset reads as long ago, so nothing stalls after reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= '1;
        end else if (restart) begin
            count <= W'(1);
        end else if (count != '1) begin
            count <= count + W'(1);
        end
    end
endmodule
`default_nettype wire

// *** rtl/act_window.sv ***
// Ages of the last few activates for the rolling activate window
`timescale 1ns/100ps
`default_nettype none
module act_window #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic act,
    input wire logic [W-1:0] window,
    output logic ok
);
    logic [W-1:0] age [DEPTH];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                age[i] <= '1;
            end
        end else if (act) begin
            age[0] <= W'(1);
            for (int i = 1; i < DEPTH; i++) begin
                age[i] <= (age[i-1] == '1) ? '1 : age[i-1] + W'(1);
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (age[i] != '1) begin
                    age[i] <= age[i] + W'(1);
                end
            end
        end
    end

    // A new activate would be the fifth once the oldest is inside the window
    always_comb begin
        ok = (age[DEPTH-1] >= window);
    end
endmodule
`default_nettype wire

// *** rtl/ddr4_cmd_spacer.sv ***
// Command spacing controller that paces commands toward a DDR4 device
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ddr4_cmd_spacer #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cmd_valid,
    input wire spacing_pkg::cmd_t cmd_in,
    output logic cmd_ready,
    output spacing_pkg::cmd_t dev_cmd
);
    import spacing_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    cfg_t cfg;
    state_t state;
    state_t next_state;
    cmd_t held;
    cmd_kind_t last_kind;
    logic [15:0] issued;
    logic [1:0] last_col_bg;
    logic [1:0] last_act_bg;
    logic [1:0] last_wr_bg;
    logic [W-1:0] col_since;
    logic [W-1:0] act_since;
    logic [W-1:0] wr_since;
    logic [W-1:0] rd_since;
    logic [W-1:0] mrs_since;
    logic [7:0] act_same;
    logic [7:0] act_other;
    logic [7:0] faw;
    logic [7:0] crc_add;
    logic [7:0] wr_start;
    logic [7:0] wtr_same;
    logic [7:0] wtr_other;
    logic [7:0] wr_pre;
    logic faw_ok;
    logic is_col;
    logic col_ok;
    logic act_ok;
    logic wtr_ok;
    logic pre_ok;
    logic mrs_ok;
    logic issue;
    logic [5:0] stall;
    logic is_act;
    logic [7:0] col_lim;
    logic [7:0] act_lim;
    logic [7:0] wtr_lim;
    logic issue_col;
    logic issue_act;
    logic issue_wr;
    logic issue_rd;
    logic issue_mrs;

    // ----------------------------------------
    // Limits chosen by configuration
    // ----------------------------------------
    always_comb begin
        case (cfg.page)
            PAGE_2K: begin
                act_other = ACT_OTHER_2K_CYC;
                act_same = ACT_SAME_2K_CYC;
                faw = FAW_2K_CYC;
            end
            PAGE_1K: begin
                act_other = cfg.grade_2666 ? ACT_OTHER_2666_CYC : ACT_OTHER_2400_CYC;
                act_same = ACT_SAME_SMALL_CYC;
                faw = FAW_1K_CYC;
            end
            PAGE_HALF: begin
                act_other = cfg.grade_2666 ? ACT_OTHER_2666_CYC : ACT_OTHER_2400_CYC;
                act_same = ACT_SAME_SMALL_CYC;
                faw = cfg.grade_2666 ? FAW_HALF_2666_CYC : FAW_HALF_2400_CYC;
            end
            default: begin
                // Unused page code falls back to the strictest limits
                act_other = ACT_OTHER_2K_CYC;
                act_same = ACT_SAME_2K_CYC;
                faw = FAW_2K_CYC;
            end
        endcase
    end

    always_comb begin
        crc_add = cfg.crc_dm ? CRC_DM_CYC : 8'h00;
        // Internal write starts after write latency plus the data burst
        wr_start = {3'h0, cfg.cwl} + BURST_HALF_CYC;
        wtr_same = wr_start + WTR_SAME_CYC + crc_add;
        wtr_other = wr_start + WTR_OTHER_CYC + crc_add;
        wr_pre = wr_start + WR_CYC + crc_add;
    end

    // ----------------------------------------
    // Limits chosen by bank group
    // ----------------------------------------
    // Each limit compares against the last command of its own kind
    always_comb begin
        if (held.bg == last_col_bg) begin
            col_lim = COL_SAME_CYC;
        end else begin
            col_lim = COL_OTHER_CYC;
        end
        if (held.bg == last_act_bg) begin
            act_lim = act_same;
        end else begin
            act_lim = act_other;
        end
        if (held.bg == last_wr_bg) begin
            wtr_lim = wtr_same;
        end else begin
            wtr_lim = wtr_other;
        end
    end

    // ----------------------------------------
    // Spacing checks on the held command
    // ----------------------------------------
    always_comb begin
        is_col = (held.kind == CMD_RD) || (held.kind == CMD_WR);
        is_act = (held.kind == CMD_ACT);
        col_ok = !is_col ||
            (col_since >= W'(col_lim));
        act_ok = !is_act ||
            ((act_since >= W'(act_lim)) && faw_ok);
        wtr_ok = (held.kind != CMD_RD) ||
            (wr_since >= W'(wtr_lim));
        // Precharge waits on the last read and write to any bank: safe, slightly slow
        pre_ok = (held.kind != CMD_PRE) ||
            ((rd_since >= W'(RTP_CYC)) && (wr_since >= W'(wr_pre)));
        mrs_ok = (held.kind != CMD_MRS) || (mrs_since >= W'(MRD_CYC));
        issue = (state == ST_HOLD) && col_ok && act_ok && wtr_ok && pre_ok && mrs_ok;
        stall = {!mrs_ok, !pre_ok, !wtr_ok, !faw_ok && is_act, !act_ok, !col_ok};
    end

    // ----------------------------------------
    // Restart strobes
    // ----------------------------------------
    // One strobe per history, so a counter restarts only on its own kind
    always_comb begin
        issue_col = issue && is_col;
        issue_act = issue && is_act;
        issue_wr = issue && (held.kind == CMD_WR);
        issue_rd = issue && (held.kind == CMD_RD);
        issue_mrs = issue && (held.kind == CMD_MRS);
    end

    // ----------------------------------------
    // History of issued commands
    // ----------------------------------------
    elapsed_counter #(.W(W)) u_col (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .restart(issue_col),
        .count(col_since)
    );

    elapsed_counter #(.W(W)) u_act (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .restart(issue_act),
        .count(act_since)
    );

    elapsed_counter #(.W(W)) u_wr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .restart(issue_wr),
        .count(wr_since)
    );

    elapsed_counter #(.W(W)) u_rd (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .restart(issue_rd),
        .count(rd_since)
    );

    elapsed_counter #(.W(W)) u_mrs (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .restart(issue_mrs),
        .count(mrs_since)
    );

    act_window #(.W(W), .DEPTH(4)) u_faw (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .act(issue_act),
        .window(W'(faw)),
        .ok(faw_ok)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            last_col_bg <= 2'h0;
            last_act_bg <= 2'h0;
            last_wr_bg <= 2'h0;
        end else if (issue) begin
            if (is_col) begin
                last_col_bg <= held.bg;
            end
            if (held.kind == CMD_ACT) begin
                last_act_bg <= held.bg;
            end
            if (held.kind == CMD_WR) begin
                last_wr_bg <= held.bg;
            end
        end
    end

    // ----------------------------------------
    // Request holding and issue
    // ----------------------------------------
    always_comb begin
        case (state)
            ST_IDLE: next_state = (cmd_valid && cmd_ready) ? ST_HOLD : ST_IDLE;
            ST_HOLD: next_state = issue ? ST_IDLE : ST_HOLD;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cmd_ready <= 1'b1;
        end else begin
            state <= next_state;
            cmd_ready <= (next_state == ST_IDLE);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            held <= '0;
        end else if (cmd_valid && cmd_ready) begin
            held <= cmd_in;
        end
    end

    // Pins idle as no-operation between commands
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dev_cmd <= '0;
        end else if (issue) begin
            dev_cmd <= held;
        end else begin
            dev_cmd <= '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            issued <= 16'h0000;
            last_kind <= CMD_NOP;
        end else if (issue) begin
            issued <= issued + 16'h0001;
            last_kind <= held.kind;
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg <= cfg_t'(CFG_RESET);
        end else if (reg_wr && (reg_addr == ADDR_CFG)) begin
            cfg <= cfg_t'(reg_wdata[CFG_WIDTH-1:0]);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CFG: reg_rdata <= {23'h0, cfg};
                ADDR_STATUS: begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[STAT_HOLD_BIT] <= (state == ST_HOLD);
                    reg_rdata[STAT_STALL_LSB +: 6] <= (state == ST_HOLD) ? stall : 6'h00;
                    reg_rdata[STAT_KIND_LSB +: 3] <= last_kind;
                end
                ADDR_ISSUED: reg_rdata <= {16'h0000, issued};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            // Data stands only in the cycle after the read strobe
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// *** verification/ddr4_cmd_spacer_monitor.sv ***
// Spacing and handshake assertions for the command spacer
`timescale 1ns/100ps
`default_nettype none
module ddr4_cmd_spacer_monitor #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic cmd_valid,
    input wire spacing_pkg::cmd_t cmd_in,
    input wire logic cmd_ready,
    input wire spacing_pkg::cmd_t dev_cmd
);
    import spacing_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Command history
    // ----------------------------------------
    logic [8:0] cfg;
    logic [31:0] now, t_col, t_mrs, t_rd, t_wr, col_lim, wtr_lim, wrec_lim, faw_lim;
    logic [31:0] t_act [4];
    logic [1:0] col_bg, wr_bg;
    logic is_col, is_act, is_rd, is_pre;
    assign is_rd = dev_cmd.kind == CMD_RD;
    assign is_col = is_rd || dev_cmd.kind == CMD_WR;
    assign is_act = dev_cmd.kind == CMD_ACT;
    assign is_pre = dev_cmd.kind == CMD_PRE;
    assign col_lim = (dev_cmd.bg == col_bg) ? 32'h5 : 32'h4;
    assign wrec_lim = 32'(cfg[8:4]) + (cfg[3] ? 32'hA : 32'h5);
    assign wtr_lim = wrec_lim + ((dev_cmd.bg == wr_bg) ? 32'h3 : 32'h1);
    assign faw_lim = (cfg[1:0] == 2'h0) ? 32'h10 : (cfg[1:0] == 2'h1) ? 32'h14 : 32'h1C;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg <= 9'h092;
        end else if (reg_wr && reg_addr == 4'h0) begin
            cfg <= reg_wdata[8:0];
        end
    end
    // Zero stamps lie far behind now, so the first command never looks close
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            now <= 32'h3E8;
            t_col <= '0;
            t_mrs <= '0;
            t_rd <= '0;
            t_wr <= '0;
            t_act <= '{default: '0};
            col_bg <= '0;
            wr_bg <= '0;
        end else begin
            now <= now + 32'h1;
            if (is_col) begin
                t_col <= now;
                col_bg <= dev_cmd.bg;
            end
            if (dev_cmd.kind == CMD_WR) begin
                t_wr <= now;
                wr_bg <= dev_cmd.bg;
            end
            if (is_rd) t_rd <= now;
            if (dev_cmd.kind == CMD_MRS) t_mrs <= now;
            if (is_act) t_act <= '{now, t_act[0], t_act[1], t_act[2]};
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_hold;
        !cmd_ready && dev_cmd == '0 ##[1:99] $rose(cmd_ready);
    endsequence
    AST_COL: assert property (is_col |-> now - t_col >= col_lim)
        else $error("column commands too close");
    AST_ACT: assert property (is_act |-> now - t_act[0] >= 32'h4)
        else $error("activates too close");
    AST_FAW: assert property (is_act |-> now - t_act[3] >= faw_lim)
        else $error("five activates in one window");
    AST_WTR: assert property (is_rd |-> now - t_wr >= wtr_lim)
        else $error("read too soon after write");
    AST_RTP: assert property (is_pre |-> now - t_rd >= 32'h4)
        else $error("precharge too soon after read");
    AST_WREC: assert property (is_pre |-> now - t_wr >= wrec_lim)
        else $error("precharge inside write recovery");
    AST_MRS: assert property (dev_cmd.kind == CMD_MRS |-> now - t_mrs >= 32'h8)
        else $error("mode set commands too close");
    AST_TAKE: assert property (s_take |=> s_hold)
        else $error("taken command not issued in time");
    AST_ISSUE: assert property ($rose(cmd_ready) |-> dev_cmd != '0)
        else $error("ready returned without a command");
    AST_PULSE: assert property (dev_cmd != '0 |=> dev_cmd == '0)
        else $error("command held on pins");
    AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    AST_CFG: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == {23'h0, cfg})
        else $error("config readback wrong");
endmodule
bind ddr4_cmd_spacer ddr4_cmd_spacer_monitor #(.W(W)) u_mon (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
    .cmd_in(cmd_in), .cmd_ready(cmd_ready), .dev_cmd(dev_cmd));
`default_nettype wire

// *** verification/ddr4_dev_model.sv ***
// Device-side model that logs every command seen on its pins
`timescale 1ns/100ps
`default_nettype none
module ddr4_dev_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire spacing_pkg::cmd_t dev_cmd
);
    import spacing_pkg::*;
    int now;
    int t_log[$];
    cmd_t c_log[$];
    // Arrival cycle and bank group kept, as spacing depends on both
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            now <= 0;
        end else begin
            now <= now + 1;
            if (dev_cmd.kind != CMD_NOP) begin
                t_log.push_back(now);
                c_log.push_back(dev_cmd);
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/ddr4_cmd_spacer_tb.sv ***
// Self-checking bench for the command spacer
`timescale 1ns/100ps
`default_nettype none
module ddr4_cmd_spacer_tb;
    import spacing_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd;
    logic cmd_valid = 1'b0;
    cmd_t cmd_in = '0;
    logic cmd_ready;
    cmd_t dev_cmd;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int sent = 0;
    int faw[3] = '{16, 20, 28};
    cmd_kind_t q_k[$];
    logic [1:0] q_bg[$];
    int q_back[$];
    int q_lo[$];
    always #20 clk_sys = ~clk_sys;
    ddr4_cmd_spacer #(.W(8)) dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_valid(cmd_valid), .cmd_in(cmd_in), .cmd_ready(cmd_ready), .dev_cmd(dev_cmd));
    ddr4_dev_model mem (.clk_sys(clk_sys), .rstn(rstn), .dev_cmd(dev_cmd));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask
    // Gaps must be exact: shorter breaks a limit, longer stalls needlessly
    task automatic check_gap(input int i, input int back, input int lo);
        int g;
        g = mem.t_log[i] - mem.t_log[i - back];
        checks++;
        if (g != lo) begin
            n_fail++;
            $display("unexpected at %0t: gap %0d want %0d", $time, g, lo);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic reg_read(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        rd = reg_rdata;
    endtask
    task automatic set_cfg(input logic [1:0] pg, input logic gr, input logic crc);
        reg_write(4'h0, {23'h0, 5'h09, crc, gr, pg});
        reg_read(4'h0);
        check_val(rd, {23'h0, 5'h09, crc, gr, pg}, "cfg");
    endtask
    task automatic add(input cmd_kind_t k, input logic [1:0] bg, input int back, input int lo);
        q_k.push_back(k);
        q_bg.push_back(bg);
        q_back.push_back(back);
        q_lo.push_back(lo);
    endtask
    // Valid held across commands so the spacer always has the next one waiting
    task automatic play(input string name);
        int base;
        base = mem.t_log.size();
        foreach (q_k[i]) begin
            cmd_in <= '{kind: q_k[i], bg: q_bg[i], ba: 2'h1, addr: 17'h0A5C3};
            cmd_valid <= 1'b1;
            @(posedge clk_sys);
            while (cmd_ready !== 1'b1) @(posedge clk_sys);
            sent++;
        end
        cmd_valid <= 1'b0;
        repeat (60) @(posedge clk_sys);
        check_val(32'(mem.t_log.size() - base), 32'(q_k.size()), name);
        foreach (q_k[i]) begin
            check_val(32'(mem.c_log[base + i].kind), 32'(q_k[i]), name);
            if (q_lo[i] > 0) check_gap(base + i, q_back[i], q_lo[i]);
        end
        $display("test %s done", name);
        q_k = {};
        q_bg = {};
        q_back = {};
        q_lo = {};
    endtask
    // ----------------------------------------
    // Timeout
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            $display("unexpected at %0t: run hung", $time);
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        reg_read(4'h0);
        check_val(rd, 32'h092, "cfg reset");
        reg_read(4'hC);
        check_val(rd, 32'h0, "unmapped");
        reg_write(4'h8, 32'hFFFF);
        $display("test registers done");
        add(CMD_RD, 2'h0, 0, 0);
        add(CMD_RD, 2'h0, 1, 5);
        add(CMD_WR, 2'h1, 1, 4);
        add(CMD_WR, 2'h1, 1, 5);
        play("columns");
        for (int p = 0; p < 3; p++) begin
            set_cfg(p[1:0], p[0], 1'b0);
            add(CMD_ACT, 2'h0, 0, 0);
            add(CMD_ACT, 2'h1, 1, 4);
            add(CMD_ACT, 2'h1, 1, 4);
            add(CMD_ACT, 2'h2, 1, 4);
            add(CMD_ACT, 2'h3, 4, faw[p]);
            play("activates");
        end
        for (int c = 0; c < 2; c++) begin
            set_cfg(2'h2, 1'b0, c[0]);
            add(CMD_WR, 2'h0, 0, 0);
            add(CMD_RD, 2'h0, 1, 17 + 5 * c);
            add(CMD_WR, 2'h0, 0, 0);
            add(CMD_RD, 2'h1, 1, 15 + 5 * c);
            add(CMD_PRE, 2'h1, 1, 4);
            add(CMD_WR, 2'h2, 0, 0);
            add(CMD_PRE, 2'h2, 1, 14 + 5 * c);
            play("turnaround");
        end
        add(CMD_MRS, 2'h0, 0, 0);
        add(CMD_MRS, 2'h0, 1, 8);
        add(CMD_MRS, 2'h3, 1, 8);
        play("mode set");
        reg_read(4'h4);
        check_val(rd & 32'h7FF, 32'h500, "status");
        reg_read(4'h8);
        check_val(rd & 32'hFFFF, 32'(sent), "issued");
        tally_and_finish();
    end
endmodule
`default_nettype wire
